// ==== design/twc_map.vh ====
`ifndef TWC_MAP_VH
`define TWC_MAP_VH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define TWC_OFF_CTRL 4'h0
`define TWC_OFF_PERIOD 4'h4
`define TWC_OFF_DUTY 4'h8
`define TWC_OFF_STATUS 4'hC
// ****************************************
// control field positions
// ****************************************
`define TWC_MODE_LSB 0
`define TWC_SSEL_LSB 4
`define TWC_CKSEL_LSB 6
`define TWC_CAPEDGE_BIT 8
`define TWC_REPEAT_BIT 9
`define TWC_POL_BIT 10
`define TWC_INIT_BIT 11
// ****************************************
// mode and start select codes
// ****************************************
`define TWC_MODE_TIMER 2'h0
`define TWC_MODE_WINDOW 2'h1
`define TWC_MODE_PWM 2'h2
`define TWC_MODE_PULSE 2'h3
`define TWC_SSEL_STOP 2'h0
`define TWC_SSEL_SW 2'h1
`define TWC_SSEL_RISE 2'h2
`define TWC_SSEL_FALL 2'h3
// ****************************************
// reset values and divider width
// ****************************************
`define TWC_CTRL_RST 12'h000
`define TWC_PERIOD_RST 16'hFFFF
`define TWC_DUTY_RST 16'h0000
`define TWC_DIV_W 4
`endif

// ==== design/twc_tick_div.v ====
`timescale 1ns/1ps
// ****************************************
// source clock tick divider
// ****************************************
module twc_tick_div #(
	parameter W = 4
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// control
	input wire [1:0] sel,
	// tick out
	output reg tick
);
	reg [W-1:0] cnt_r;
	reg [W-1:0] lim;
	always @* begin
		case (sel)
		2'h0: lim = {W{1'b1}};
		2'h1: lim = {{(W-2){1'b0}}, 2'h3};
		2'h2: lim = {{(W-1){1'b0}}, 1'b1};
		default: lim = {W{1'b0}};
		endcase
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= {W{1'b0}};
			tick <= 1'b0;
		end else if (cnt_r >= lim) begin
			cnt_r <= {W{1'b0}};
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule // twc_tick_div

// ==== design/twc_timer.v ====
// Contract
// - window mode counts source ticks gated by the input pin
// - window polarity bit picks counting while high or while low
// - window count equal to period raises match irq and clears
// - width mode starts on the chosen trigger edge, counts ticks
// - capture edge bit: 1 single-edge, 0 double-edge
// - single-edge: opposite edge captures, irq, sets count to one, waits trigger
// - double-edge: capture both edges, clear at trigger, keep counting
// - single-edge counter holds at one after capture until next edge
// - pulse mode starts on pin edge or software start
// - repeat bit: 0 continuous, 1 one-shot
// - duty and period matches toggle output and irq; period clears
// - start select cleared to stop keeps the output level
// - one-shot period match toggles, irq, clears start select
// - output pin is inverse of flop; init bit loads flop
// - init bit loads only when entering pulse mode
`timescale 1ns/1ps
`include "twc_map.vh"
module twc_timer #(
	parameter CW = 16
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// pins
	input wire timer_input_pin,
	output wire pulse_output_pin,
	output reg timer_match_irq
);
	// ****************************************
	// registers
	// ****************************************
	reg [11:0] timer_control_reg;
	reg [CW-1:0] compare_period_reg;
	reg [CW-1:0] capture_duty_reg;
	reg [CW-1:0] count_r;
	reg flop_r;
	reg run_r;
	reg pin_s1_r, pin_s2_r, pin_d_r;
	reg [3:0] aw_a_r;
	reg [31:0] w_d_r;
	reg [3:0] w_s_r;
	reg aw_ok_r, w_ok_r;
	wire tick;
	wire [1:0] mode = timer_control_reg[`TWC_MODE_LSB+1:`TWC_MODE_LSB];
	wire [1:0] ssel = timer_control_reg[`TWC_SSEL_LSB+1:`TWC_SSEL_LSB];
	wire [1:0] cksel = timer_control_reg[`TWC_CKSEL_LSB+1:`TWC_CKSEL_LSB];
	wire capture_edge_mode = timer_control_reg[`TWC_CAPEDGE_BIT];
	wire pulse_repeat_mode = timer_control_reg[`TWC_REPEAT_BIT];
	wire win_pol = timer_control_reg[`TWC_POL_BIT];
	wire output_flop_init = timer_control_reg[`TWC_INIT_BIT];
	// ****************************************
	// pin synchroniser and edges
	// ****************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			pin_d_r <= 1'b0;
		end else begin
			pin_s1_r <= timer_input_pin;
			pin_s2_r <= pin_s1_r;
			pin_d_r <= pin_s2_r;
		end
	end
	wire rise = pin_s2_r & ~pin_d_r;
	wire fall = ~pin_s2_r & pin_d_r;
	wire trig = (ssel == `TWC_SSEL_RISE) ? rise :
		(ssel == `TWC_SSEL_FALL) ? fall : 1'b0;
	wire opp = (ssel == `TWC_SSEL_RISE) ? fall :
		(ssel == `TWC_SSEL_FALL) ? rise : 1'b0;
	twc_tick_div #(.W(`TWC_DIV_W)) u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.sel(cksel),
		.tick(tick)
	);
	// ****************************************
	// axi4-lite write
	// ****************************************
	assign s_axi_awready = ~aw_ok_r & ~s_axi_bvalid;
	assign s_axi_wready = ~w_ok_r & ~s_axi_bvalid;
	wire wr_go = aw_ok_r & w_ok_r;
	wire wr_ctrl = wr_go & (aw_a_r == `TWC_OFF_CTRL);
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_r <= 1'b0;
			w_ok_r <= 1'b0;
			aw_a_r <= 4'h0;
			w_d_r <= 32'h0;
			w_s_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_r <= 1'b1;
				aw_a_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_r <= 1'b1;
				w_d_r <= s_axi_wdata;
				w_s_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_ok_r <= 1'b0;
				w_ok_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_a_r == `TWC_OFF_STATUS) ? 2'h2 : 2'h0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// ****************************************
	// axi4-lite read
	// ****************************************
	assign s_axi_arready = ~s_axi_rvalid;
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (s_axi_araddr)
			`TWC_OFF_CTRL: s_axi_rdata <= {20'h0, timer_control_reg};
			`TWC_OFF_PERIOD: s_axi_rdata <= {16'h0, compare_period_reg};
			`TWC_OFF_DUTY: s_axi_rdata <= {16'h0, capture_duty_reg};
			`TWC_OFF_STATUS:
				s_axi_rdata <= {14'h0, run_r, ~flop_r, count_r};
			default: begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= 2'h2;
			end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	// ****************************************
	// timer core
	// ****************************************
	wire [1:0] new_mode = w_s_r[0] ? w_d_r[1:0] : mode;
	wire enter_pulse = wr_ctrl && new_mode == `TWC_MODE_PULSE &&
		mode != `TWC_MODE_PULSE;
	wire next_flop_init = w_s_r[1] ? w_d_r[`TWC_INIT_BIT] : output_flop_init;
	wire hit_per = tick && count_r == compare_period_reg;
	wire hit_duty = tick && count_r == capture_duty_reg;
	wire gate = win_pol ? ~pin_s2_r : pin_s2_r;
	reg one_shot_end;
	always @(posedge aclk) begin
		if (!aresetn) begin
			timer_control_reg <= `TWC_CTRL_RST;
			compare_period_reg <= `TWC_PERIOD_RST;
			capture_duty_reg <= `TWC_DUTY_RST;
			count_r <= {CW{1'b0}};
			flop_r <= 1'b0;
			run_r <= 1'b0;
			timer_match_irq <= 1'b0;
			one_shot_end <= 1'b0;
		end else begin
			timer_match_irq <= 1'b0;
			one_shot_end <= 1'b0;
			if (wr_go && aw_a_r == `TWC_OFF_PERIOD) begin
				if (w_s_r[0]) compare_period_reg[7:0] <= w_d_r[7:0];
				if (w_s_r[1]) compare_period_reg[15:8] <= w_d_r[15:8];
			end
			if (wr_go && aw_a_r == `TWC_OFF_DUTY) begin
				if (w_s_r[0]) capture_duty_reg[7:0] <= w_d_r[7:0];
				if (w_s_r[1]) capture_duty_reg[15:8] <= w_d_r[15:8];
			end
			if (wr_ctrl) begin
				if (w_s_r[0]) timer_control_reg[7:0] <= w_d_r[7:0];
				if (w_s_r[1]) timer_control_reg[11:8] <= w_d_r[11:8];
			end
			if (enter_pulse)
				flop_r <= next_flop_init;
			if (ssel == `TWC_SSEL_STOP || wr_ctrl) begin
				if (ssel == `TWC_SSEL_STOP) begin
					run_r <= 1'b0;
					count_r <= {CW{1'b0}};
				end
			end else case (mode)
			`TWC_MODE_WINDOW: begin
				if (tick && gate) begin
					if (count_r == compare_period_reg) begin
						timer_match_irq <= 1'b1;
						count_r <= {CW{1'b0}};
					end else
						count_r <= count_r + 1'b1;
				end
			end
			`TWC_MODE_PWM: begin
				if (!run_r) begin
					if (trig) begin
						run_r <= 1'b1;
						if (!capture_edge_mode)
							count_r <= {CW{1'b0}};
					end
				end else if (opp) begin
					capture_duty_reg <= count_r;
					timer_match_irq <= 1'b1;
					if (capture_edge_mode) begin
						count_r <= {{(CW-1){1'b0}}, 1'b1};
						run_r <= 1'b0;
					end else if (tick)
						count_r <= count_r + 1'b1;
				end else if (trig && !capture_edge_mode) begin
					capture_duty_reg <= count_r;
					timer_match_irq <= 1'b1;
					count_r <= {CW{1'b0}};
				end else if (tick)
					count_r <= count_r + 1'b1;
			end
			`TWC_MODE_PULSE: begin
				if (!run_r) begin
					// no restart while the one-shot stop is pending
					if (!one_shot_end && (ssel == `TWC_SSEL_SW || trig))
						run_r <= 1'b1;
				end else if (hit_per) begin
					flop_r <= ~flop_r;
					timer_match_irq <= 1'b1;
					count_r <= {CW{1'b0}};
					if (pulse_repeat_mode) begin
						one_shot_end <= 1'b1;
						run_r <= 1'b0;
					end
				end else if (hit_duty) begin
					flop_r <= ~flop_r;
					timer_match_irq <= 1'b1;
					count_r <= count_r + 1'b1;
				end else if (tick)
					count_r <= count_r + 1'b1;
			end
			default: begin
				run_r <= 1'b0;
			end
			endcase
			if (one_shot_end && !wr_ctrl)
				timer_control_reg[`TWC_SSEL_LSB+1:`TWC_SSEL_LSB]
					<= `TWC_SSEL_STOP;
		end
	end
	assign pulse_output_pin = ~flop_r;
endmodule // twc_timer

// ==== verification/twc_chk.sv ====
`timescale 1ns/1ps
module twc_chk (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// write side
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	// read side
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// pins
	input wire pulse_output_pin,
	input wire timer_match_irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire wgo = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
	wire rgo = s_axi_arvalid & s_axi_arready;
	chk_b_hold: assert property (s_axi_bvalid & !s_axi_bready |=>
		s_axi_bvalid & $stable(s_axi_bresp)) else $error("bvalid lost");
	chk_r_hold: assert property (s_axi_rvalid & !s_axi_rready |=>
		s_axi_rvalid) else $error("rvalid lost");
	// address and data latch one cycle, the response follows one later
	chk_b_answer: assert property (wgo |-> ##2 s_axi_bvalid)
		else $error("no write answer");
	chk_r_answer: assert property (rgo |=> s_axi_rvalid)
		else $error("no read answer");
	chk_w_refuse: assert property (s_axi_bvalid |-> !s_axi_awready &
		!s_axi_wready) else $error("write taken while busy");
	chk_r_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	chk_status_ro: assert property (wgo & s_axi_awaddr == 4'hC |->
		##2 s_axi_bresp == 2'h2) else $error("status write accepted");
	chk_pin_cause: assert property (
		$changed(pulse_output_pin) |-> timer_match_irq |
		$past(s_axi_wvalid) | $past(s_axi_wvalid, 2))
		else $error("pin moved without cause");
	chk_reset_out: assert property (disable iff (1'b0)
		!aresetn |=> pulse_output_pin & !timer_match_irq &
		!s_axi_bvalid & !s_axi_rvalid) else $error("bad reset state");
	cover property (timer_match_irq);
	cover property ($fell(pulse_output_pin));
	cover property (s_axi_bvalid & s_axi_bresp == 2'h2);
endmodule // twc_chk

// ==== verification/twc_pin_src.sv ====
`timescale 1ns/1ps
module twc_pin_src (
	// clock
	input wire aclk,
	// pulse shape, widths in cycles minus one
	input wire src_en,
	input wire [7:0] src_hi,
	input wire [7:0] src_lo,
	// driven pin
	output reg timer_input_pin
);
	reg [7:0] cnt_r;
	initial begin
		timer_input_pin = 1'b0;
		cnt_r = 8'h00;
	end
	always @(posedge aclk) begin
		if (!src_en) begin
			timer_input_pin <= 1'b0;
			cnt_r <= 8'h00;
		end else if (cnt_r == 8'h00) begin
			timer_input_pin <= !timer_input_pin;
			cnt_r <= timer_input_pin ? src_lo : src_hi;
		end else begin
			cnt_r <= cnt_r - 8'h01;
		end
	end
endmodule // twc_pin_src

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	reg aclk = 1'b0;
	reg aresetn = 1'b0;
	reg [3:0] s_axi_awaddr = 4'h0;
	reg s_axi_awvalid = 1'b0;
	wire s_axi_awready;
	reg [31:0] s_axi_wdata = 32'h0;
	wire [3:0] s_axi_wstrb = 4'hF;
	reg s_axi_wvalid = 1'b0;
	wire s_axi_wready;
	wire [1:0] s_axi_bresp;
	wire s_axi_bvalid;
	reg s_axi_bready = 1'b0;
	reg [3:0] s_axi_araddr = 4'h0;
	reg s_axi_arvalid = 1'b0;
	wire s_axi_arready;
	wire [31:0] s_axi_rdata;
	wire [1:0] s_axi_rresp;
	wire s_axi_rvalid;
	reg s_axi_rready = 1'b0;
	wire timer_input_pin;
	wire pulse_output_pin;
	wire timer_match_irq;
	reg src_en = 1'b0;
	wire [7:0] src_hi = 8'h27;
	wire [7:0] src_lo = 8'h13;
	integer fails = 0;
	integer compares = 0;
	integer i, c, c2;
	reg rw;
	reg [3:0] ra;
	reg [1:0] r, eb, er;
	reg [31:0] q, a, rd, e;
	reg [31:0] cap [0:2];
	reg [72:0] rows [0:4];
	twc_timer twc_timer_inst (.*);
	twc_pin_src twc_pin_src_inst (.*);
	initial forever #2.5 aclk = !aclk;
	task report_and_stop;
		begin
			$display("compares %0d fails %0d", compares, fails);
			if (fails == 0 && compares > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] x);
		begin
			compares = compares + 1;
			if (g !== x) begin
				fails = fails + 1;
				$display("Error at %0t: got %h want %h", $time, g, x);
			end
		end
	endtask
	task hang;
		begin
			fails = fails + 1;
			$display("Error at %0t: wait ran out", $time);
			report_and_stop;
		end
	endtask
	// ****************************************
	// bus master, one transfer
	// ****************************************
	task xfer(input w, input [3:0] ad, input [31:0] d);
		integer n;
		reg ta, tw, tr, dn;
		begin
			@(posedge aclk);
			s_axi_awaddr <= ad;
			s_axi_araddr <= ad;
			s_axi_wdata <= d;
			s_axi_awvalid <= w;
			s_axi_wvalid <= w;
			s_axi_bready <= w;
			s_axi_arvalid <= !w;
			s_axi_rready <= !w;
			dn = 1'b0;
			for (n = 0; n < 50 && !dn; n = n + 1) begin
				@(negedge aclk);
				ta = s_axi_awvalid & s_axi_awready;
				tw = s_axi_wvalid & s_axi_wready;
				tr = s_axi_arvalid & s_axi_arready;
				dn = w ? s_axi_bvalid : s_axi_rvalid;
				q = s_axi_rdata;
				r = w ? s_axi_bresp : s_axi_rresp;
				@(posedge aclk);
				if (ta)
					s_axi_awvalid <= 1'b0;
				if (tw)
					s_axi_wvalid <= 1'b0;
				if (tr)
					s_axi_arvalid <= 1'b0;
			end
			s_axi_bready <= 1'b0;
			s_axi_rready <= 1'b0;
			if (!dn)
				hang;
		end
	endtask
	// s=1 waits for a pin change, s=0 for a match pulse
	task wait_ev(input s, output integer cnt);
		reg p;
		integer n;
		begin
			p = pulse_output_pin;
			cnt = 0;
			for (n = 1; n < 400 && cnt == 0; n = n + 1) begin
				@(negedge aclk);
				if (s ? pulse_output_pin !== p : timer_match_irq === 1'b1)
					cnt = n;
			end
			if (cnt == 0)
				hang;
		end
	endtask
	task caps(input [31:0] ctl);
		begin
			xfer(1'b1, 4'h0, ctl);
			wait_ev(1'b0, c);
			for (i = 0; i < 3; i = i + 1) begin
				wait_ev(1'b0, c);
				xfer(1'b0, 4'h8, 32'h0);
				cap[i] = q;
			end
		end
	endtask
	initial begin
		rows[0] = {1'b1, 4'h4, 32'h1234, 32'h1234, 2'h0, 2'h0};
		rows[1] = {1'b1, 4'h8, 32'hFFFF_00AB, 32'h00AB, 2'h0, 2'h0};
		rows[2] = {1'b1, 4'h0, 32'hFFFF_F0C0, 32'h00C0, 2'h0, 2'h0};
		rows[3] = {1'b1, 4'hC, 32'h5555, 32'h1_0000, 2'h2, 2'h0};
		rows[4] = {1'b0, 4'h2, 32'h0, 32'h0, 2'h0, 2'h2};
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 5; i = i + 1) begin
			{rw, ra, rd, e, eb, er} = rows[i];
			if (rw) begin
				xfer(1'b1, ra, rd);
				chk(r, eb);
			end
			xfer(1'b0, ra, 32'h0);
			chk(q, e);
			chk(r, er);
		end
		@(posedge aclk);
		aresetn <= 1'b0;
		@(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk(pulse_output_pin, 1'b1);
		for (i = 0; i < 3; i = i + 1) begin
			xfer(1'b0, {i[1:0], 2'b00}, 32'h0);
			chk(q, i == 1 ? 32'hFFFF : 32'h0);
		end
		xfer(1'b1, 4'h4, 32'h10);
		xfer(1'b1, 4'h0, 32'h0D1);
		repeat (40) @(posedge aclk);
		xfer(1'b0, 4'hC, 32'h0);
		chk(q[15:0], 16'h0);
		xfer(1'b1, 4'h0, 32'h4D1);
		wait_ev(1'b0, c);
		wait_ev(1'b0, c);
		chk(c == 16 || c == 17, 1'b1);
		xfer(1'b1, 4'h0, 32'h0C3);
		xfer(1'b1, 4'h4, 32'h20);
		xfer(1'b1, 4'h8, 32'h08);
		@(negedge aclk);
		chk(pulse_output_pin, 1'b1);
		xfer(1'b1, 4'h0, 32'h0D3);
		wait_ev(1'b1, c);
		wait_ev(1'b1, c);
		wait_ev(1'b1, c2);
		chk(c == 24 || c2 == 24, 1'b1);
		xfer(1'b1, 4'h0, 32'h0C3);
		@(negedge aclk);
		a = pulse_output_pin;
		repeat (60) @(negedge aclk);
		chk(pulse_output_pin, a);
		xfer(1'b1, 4'h0, 32'h0C0);
		xfer(1'b1, 4'h0, 32'hAC3);
		@(negedge aclk);
		chk(pulse_output_pin, 1'b0);
		xfer(1'b1, 4'h0, 32'hAD3);
		wait_ev(1'b0, c);
		repeat (60) @(negedge aclk);
		a = pulse_output_pin;
		xfer(1'b0, 4'h0, 32'h0);
		chk(q, 32'hAC3);
		repeat (60) @(negedge aclk);
		chk(pulse_output_pin, a);
		xfer(1'b1, 4'h0, 32'h2C3);
		@(negedge aclk);
		chk(pulse_output_pin, a);
		src_en <= 1'b1;
		caps(32'h1E2);
		chk(cap[1] == cap[0] && cap[2] == cap[0], 1'b1);
		chk(cap[0] > 37 && cap[0] < 44, 1'b1);
		caps(32'h0E2);
		e = cap[0] > cap[1] ? cap[0] - cap[1] : cap[1] - cap[0];
		chk(cap[0], cap[2]);
		chk(e > 18 && e < 22, 1'b1);
		report_and_stop;
	end
endmodule // testbench
bind twc_timer twc_chk twc_chk_inst (.*);
